// file: core_memory_space_addressing.sv
`timescale 1ns/1ps
`include "core_addr_consts.svh"

// Summary of operation
// - special registers live at 0x80-0xFF and only direct and bit addressing reach them
// - bit-addressable special registers allow single-bit read and modify
// - 2 kB extended ram at 0x000-0x7FF, reached only by extended moves
// - no off-chip data memory; extended accesses to 0x000-0x7FF served on chip, data pointer beyond 0x7FF flagged as error
// - 62 kB flash holds code and constants; read by code-indirect moves
// - immediates come from program memory: byte 2/2, data pointer 3/3
// - working register to accumulator is one byte, one cycle, fastest
// - addresses 0x00-0x7F reach ram by direct or indirect addressing
// - direct addresses 0x80-0xFF go to special registers, not ram
// - indirect addresses 0x80-0xFF go to upper ram, never special registers
// - indirect ram read into accumulator is one byte, two cycles
// - data pointer extended access uses pointer as address; one byte, four cycles
// - pointer register extended access uses register as address; one byte, four cycles
// - pointer load plus pointer extended read totals seven cycles
// - code reads at acc+data_pointer or acc+pc take four; jump acc+data_pointer three
// - ram bytes 0x20-0x2F are bit-addressable via bit addresses 0x00-0x7F
// - upper ram shares 0x80-0xFF with special registers; mode selects

module core_memory_space_addressing (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             req_valid,
  input  core_addr_pkg::req_t   req,
  input  wire logic [15:0]      data_pointer,
  input  wire logic [7:0]       accumulator,
  input  wire logic [15:0]      program_counter,
  input  wire logic             flash_load_valid,
  input  wire logic [15:0]      flash_load_addr,
  input  wire logic [7:0]       flash_load_data,
  output logic                  req_ready,
  output core_addr_pkg::rsp_t   rsp
);

  core_addr_pkg::route_t route;
  logic [7:0]  iram_q  [0:`IRAM_BYTES-1];
  logic [7:0]  sfr_q   [0:`SFR_BYTES-1];
  logic [7:0]  extended_internal_ram_q  [0:`EXTENDED_INTERNAL_RAM_BYTES-1];
  logic [7:0]  flash_q [0:`FLASH_BYTES-1];
  logic [2:0]  cnt_q;
  logic        busy_q;
  logic        accept;
  logic [7:0]  byte_rd;
  logic [15:0] word_rd;
  logic [7:0]  bit_byte_d;
  logic        bit_now;
  core_addr_pkg::rsp_t rsp_hold_q;

  // flash reads past the top of the space return erased data
  function automatic logic [7:0] flash_byte(input logic [15:0] a);
    logic [7:0] v;
    v = 8'hFF;
    if (a <= `FLASH_LAST) begin
      v = flash_q[a];
    end
    return v;
  endfunction

  operand_router u_router (
    .req             (req),
    .data_pointer    (data_pointer),
    .accumulator     (accumulator),
    .program_counter (program_counter),
    .route           (route)
  );

  // take only while ready is shown, so the first edge after reset cannot take unseen
  assign accept = req_valid && req_ready;

  // one read port shared by all spaces, selected by the routed space
  always_comb begin
    byte_rd = 8'h00;
    case (route.space)
      core_addr_pkg::space_iram:  byte_rd = iram_q[route.addr[7:0]];
      core_addr_pkg::space_sfr:   byte_rd = sfr_q[route.addr[6:0]];
      core_addr_pkg::space_extended_internal_ram:  byte_rd = extended_internal_ram_q[route.addr[10:0]];
      core_addr_pkg::space_flash: byte_rd = flash_byte(route.addr);
      default:                    byte_rd = 8'h00;
    endcase
  end

  // sixteen-bit results: pointer immediates and jump targets
  always_comb begin
    word_rd = {8'h00, byte_rd};
    case (req.mode)
      core_addr_pkg::mode_imm_data_pointer:
        word_rd = {flash_byte(route.addr), flash_byte(route.addr + 16'h0001)};
      core_addr_pkg::mode_jump_data_pointer:
        word_rd = route.addr;
      default:
        word_rd = {8'h00, byte_rd};
    endcase
  end

  // read-modify-write of one bit in the selected byte
  always_comb begin
    bit_now    = byte_rd[route.bit_sel];
    bit_byte_d = byte_rd;
    case (req.bit_op)
      core_addr_pkg::bit_set:    bit_byte_d[route.bit_sel] = 1'b1;
      core_addr_pkg::bit_clear:  bit_byte_d[route.bit_sel] = 1'b0;
      core_addr_pkg::bit_invert: bit_byte_d[route.bit_sel] = !bit_now;
      default:                   bit_byte_d = byte_rd;
    endcase
  end

  // internal ram: byte writes by direct, register, indirect; bit writes
  always_ff @(posedge clk) begin
    if (accept && !route.err && route.space == core_addr_pkg::space_iram) begin
      if (req.mode == core_addr_pkg::mode_bit) begin
        iram_q[route.addr[7:0]] <= bit_byte_d;
      end else if (req.write) begin
        iram_q[route.addr[7:0]] <= req.wdata;
      end
    end
  end

  // special register storage; only direct and bit modes route here
  always_ff @(posedge clk) begin
    if (accept && route.space == core_addr_pkg::space_sfr) begin
      if (req.mode == core_addr_pkg::mode_bit) begin
        sfr_q[route.addr[6:0]] <= bit_byte_d;
      end else if (req.write) begin
        sfr_q[route.addr[6:0]] <= req.wdata;
      end
    end
  end

  // extended ram; an out-of-range pointer write is dropped, not wrapped
  always_ff @(posedge clk) begin
    if (accept && req.write && !route.err && route.space == core_addr_pkg::space_extended_internal_ram) begin
      extended_internal_ram_q[route.addr[10:0]] <= req.wdata;
    end
  end

  // flash is read-only to the core; filled through the load port
  always_ff @(posedge clk) begin
    if (flash_load_valid && flash_load_addr <= `FLASH_LAST) begin
      flash_q[flash_load_addr] <= flash_load_data;
    end
  end

  // cycle cost counter: answer comes route.cycles edges after accept
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      busy_q <= 1'b0;
      cnt_q  <= 3'h0;
    end else if (accept) begin
      busy_q <= 1'b1;
      cnt_q  <= route.cycles;
    end else if (busy_q) begin
      cnt_q  <= cnt_q - 3'h1;
      if (cnt_q == 3'h1) begin
        busy_q <= 1'b0;
      end
    end
  end

  // ready is loaded from the next idle state so it matches idle in the same cycle and stays a flop output
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      req_ready <= 1'b0;
    end else begin
      req_ready <= !(accept || (busy_q && cnt_q != 3'h1));
    end
  end

  // result captured at accept, held until the cost has elapsed
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rsp_hold_q <= '0;
    end else if (accept) begin
      rsp_hold_q.valid     <= 1'b1;
      rsp_hold_q.rdata     <= route.err ? 16'h00FF : word_rd;
      rsp_hold_q.bit_value <= bit_now;
      rsp_hold_q.space     <= route.space;
      rsp_hold_q.bytes     <= route.bytes;
      rsp_hold_q.err       <= route.err;
    end
  end

  // response is a one-cycle pulse at the end of the cycle count
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rsp <= '0;
    end else if (busy_q && cnt_q == 3'h1) begin
      rsp <= rsp_hold_q;
    end else begin
      rsp.valid <= 1'b0;
    end
  end

endmodule

// file: core_addr_consts.svh
`ifndef CORE_ADDR_CONSTS_SVH
`define CORE_ADDR_CONSTS_SVH

// memory sizes in bytes
`define IRAM_BYTES        256
`define SFR_BYTES         128
`define EXTENDED_INTERNAL_RAM_BYTES        2048
`define FLASH_BYTES       63488

// internal data space boundaries
`define SFR_BASE          8'h80
`define BIT_RAM_BASE      8'h20
`define BIT_SFR_MASK      8'hF8
`define EXTENDED_INTERNAL_RAM_LAST         16'h07FF
`define FLASH_LAST        16'hF7FF

// core clock cycles per addressing mode
`define CYC_IMM_BYTE      3'h2
`define CYC_IMM_DATA_POINTER      3'h3
`define CYC_DIRECT        3'h2
`define CYC_REGISTER      3'h1
`define CYC_INDIRECT      3'h2
`define CYC_EXT           3'h4
`define CYC_CODE          3'h4
`define CYC_JUMP          3'h3
`define CYC_BIT           3'h2

// instruction bytes per addressing mode
`define LEN_IMM_BYTE      2'h2
`define LEN_IMM_DATA_POINTER      2'h3
`define LEN_DIRECT        2'h2
`define LEN_ONE           2'h1

`endif

// file: core_addr_pkg.sv
package core_addr_pkg;

  typedef enum logic [3:0] {
    mode_imm_byte,
    mode_imm_data_pointer,
    mode_direct,
    mode_register,
    mode_indirect,
    mode_ext_data_pointer,
    mode_ext_ptr,
    mode_code_data_pointer,
    mode_code_pc,
    mode_jump_data_pointer,
    mode_bit
  } mode_t;

  typedef enum logic [1:0] {
    bit_read,
    bit_set,
    bit_clear,
    bit_invert
  } bit_op_t;

  typedef enum logic [2:0] {
    space_none,
    space_iram,
    space_sfr,
    space_extended_internal_ram,
    space_flash
  } space_t;

  typedef struct packed {
    mode_t       mode;
    logic        write;
    bit_op_t     bit_op;
    logic [7:0]  addr;
    logic [7:0]  wdata;
  } req_t;

  typedef struct packed {
    space_t      space;
    logic [15:0] addr;
    logic [2:0]  bit_sel;
    logic [2:0]  cycles;
    logic [1:0]  bytes;
    logic        err;
  } route_t;

  typedef struct packed {
    logic        valid;
    logic [15:0] rdata;
    logic        bit_value;
    space_t      space;
    logic [1:0]  bytes;
    logic        err;
  } rsp_t;

endpackage

// file: operand_router.sv
`timescale 1ns/1ps
`include "core_addr_consts.svh"

module operand_router (
  input  core_addr_pkg::req_t   req,
  input  wire logic [15:0]      data_pointer,
  input  wire logic [7:0]       accumulator,
  input  wire logic [15:0]      program_counter,
  output core_addr_pkg::route_t route
);

  logic [15:0] code_data_pointer_addr;
  logic [15:0] code_pc_addr;

  // code reads index from the accumulator, wrapping at 64k
  assign code_data_pointer_addr = data_pointer + {8'h00, accumulator};
  assign code_pc_addr   = program_counter + {8'h00, accumulator};

  // the addressing mode picks the memory space; direct and bit modes also use the address top bit
  always_comb begin
    route         = '0;
    route.space   = core_addr_pkg::space_none;
    route.bytes   = `LEN_ONE;
    case (req.mode)
      core_addr_pkg::mode_imm_byte: begin
        route.space  = core_addr_pkg::space_flash;
        route.addr   = program_counter + 16'h0001;
        route.cycles = `CYC_IMM_BYTE;
        route.bytes  = `LEN_IMM_BYTE;
      end
      core_addr_pkg::mode_imm_data_pointer: begin
        route.space  = core_addr_pkg::space_flash;
        route.addr   = program_counter + 16'h0001;
        route.cycles = `CYC_IMM_DATA_POINTER;
        route.bytes  = `LEN_IMM_DATA_POINTER;
      end
      core_addr_pkg::mode_direct: begin
        // upper half of a direct address is the register space
        route.space  = (req.addr >= `SFR_BASE) ? core_addr_pkg::space_sfr
                                               : core_addr_pkg::space_iram;
        route.addr   = {8'h00, req.addr};
        route.cycles = `CYC_DIRECT;
        route.bytes  = `LEN_DIRECT;
      end
      core_addr_pkg::mode_register: begin
        // working registers sit in bank zero of internal ram
        route.space  = core_addr_pkg::space_iram;
        route.addr   = {13'h0000, req.addr[2:0]};
        route.cycles = `CYC_REGISTER;
      end
      core_addr_pkg::mode_indirect: begin
        route.space  = core_addr_pkg::space_iram;
        route.addr   = {8'h00, req.addr};
        route.cycles = `CYC_INDIRECT;
      end
      core_addr_pkg::mode_ext_data_pointer: begin
        route.space  = core_addr_pkg::space_extended_internal_ram;
        route.addr   = data_pointer;
        route.err    = (data_pointer > `EXTENDED_INTERNAL_RAM_LAST);
        route.cycles = `CYC_EXT;
      end
      core_addr_pkg::mode_ext_ptr: begin
        route.space  = core_addr_pkg::space_extended_internal_ram;
        route.addr   = {8'h00, req.addr};
        route.cycles = `CYC_EXT;
      end
      core_addr_pkg::mode_code_data_pointer: begin
        route.space  = core_addr_pkg::space_flash;
        route.addr   = code_data_pointer_addr;
        route.err    = (code_data_pointer_addr > `FLASH_LAST);
        route.cycles = `CYC_CODE;
      end
      core_addr_pkg::mode_code_pc: begin
        route.space  = core_addr_pkg::space_flash;
        route.addr   = code_pc_addr;
        route.err    = (code_pc_addr > `FLASH_LAST);
        route.cycles = `CYC_CODE;
      end
      core_addr_pkg::mode_jump_data_pointer: begin
        route.space  = core_addr_pkg::space_none;
        route.addr   = code_data_pointer_addr;
        route.err    = (code_data_pointer_addr > `FLASH_LAST);
        route.cycles = `CYC_JUMP;
      end
      core_addr_pkg::mode_bit: begin
        route.cycles  = `CYC_BIT;
        route.bytes   = `LEN_DIRECT;
        route.bit_sel = req.addr[2:0];
        if (req.addr < `SFR_BASE) begin
          // low bit addresses cover sixteen ram bytes
          route.space = core_addr_pkg::space_iram;
          route.addr  = {8'h00, `BIT_RAM_BASE + {4'h0, req.addr[6:3]}};
        end else begin
          route.space = core_addr_pkg::space_sfr;
          route.addr  = {8'h00, req.addr & `BIT_SFR_MASK};
        end
      end
      default: begin
        route.err    = 1'b1;
        route.cycles = `CYC_REGISTER;
      end
    endcase
  end

endmodule

// file: addr_space_checker.sv
`timescale 1ns/1ps
module addr_space_checker (
  input wire logic           clk,
  input wire logic           rst,
  input wire logic           req_valid,
  input core_addr_pkg::req_t req,
  input wire logic [15:0]    data_pointer,
  input wire logic           req_ready,
  input core_addr_pkg::rsp_t rsp
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  // a request counts only when the core is idle; a refused one must not start timing
  wire logic take;
  assign take = req_valid && req_ready;

  // answer timing and routing per addressing mode
  // the answer flop rises N edges after the take, so it is sampled one edge later
  AST_REG_ONE_CYCLE: assert property (take && req.mode == core_addr_pkg::mode_register
    |=> !rsp.valid ##1 rsp.valid && rsp.bytes == 2'h1) else $error("register move not one cycle");
  AST_INDIRECT_UPPER: assert property (take && req.mode == core_addr_pkg::mode_indirect
    |=> !rsp.valid [*2] ##1 rsp.valid && rsp.space == core_addr_pkg::space_iram)
    else $error("indirect access not ram in two cycles");
  AST_DIRECT_SFR: assert property (take && req.mode == core_addr_pkg::mode_direct
    && req.addr[7] |-> ##3 rsp.valid && rsp.space == core_addr_pkg::space_sfr)
    else $error("upper direct access missed special registers");
  AST_DIRECT_LOW: assert property (take && req.mode == core_addr_pkg::mode_direct
    && !req.addr[7] |-> ##3 rsp.valid && rsp.space == core_addr_pkg::space_iram
    && rsp.bytes == 2'h2)
    else $error("low direct access not ram");
  AST_IMM_DATA_POINTER: assert property (take && req.mode == core_addr_pkg::mode_imm_data_pointer
    |=> !rsp.valid [*3] ##1 rsp.valid && rsp.bytes == 2'h3)
    else $error("pointer immediate cost wrong");
  AST_EXT_PTR: assert property (take && req.mode == core_addr_pkg::mode_ext_ptr
    |=> !rsp.valid [*4] ##1 rsp.valid && rsp.space == core_addr_pkg::space_extended_internal_ram && !rsp.err)
    else $error("pointer register extended access wrong");
  AST_EXT_DATA_POINTER: assert property (take && req.mode == core_addr_pkg::mode_ext_data_pointer
    && data_pointer <= 16'h07FF |-> ##5 rsp.valid && rsp.space == core_addr_pkg::space_extended_internal_ram)
    else $error("data pointer extended access wrong");
  AST_EXT_RANGE: assert property (take && req.mode == core_addr_pkg::mode_ext_data_pointer
    && data_pointer > 16'h07FF |-> ##5 rsp.valid && rsp.err && rsp.rdata == 16'h00FF)
    else $error("extended access beyond 2 kB not refused");
  AST_CODE_PC: assert property (take && req.mode == core_addr_pkg::mode_code_pc
    |-> ##5 rsp.valid && rsp.space == core_addr_pkg::space_flash)
    else $error("code read not flash in four cycles");
  // the bit address is taken from the take edge, not from whatever stands later
  AST_BIT_SPACE: assert property (take && req.mode == core_addr_pkg::mode_bit
    |-> ##3 rsp.valid && rsp.space == ($past(req.addr[7], 3) ? core_addr_pkg::space_sfr
    : core_addr_pkg::space_iram)) else $error("bit access in wrong space");

  // main scenarios reached
  cover property (take && req.mode == core_addr_pkg::mode_bit);
  cover property (rsp.valid && rsp.err);
  cover property (take && req.mode == core_addr_pkg::mode_jump_data_pointer);
endmodule

bind core_memory_space_addressing addr_space_checker chk_u (
  .clk(clk), .rst(rst), .req_valid(req_valid), .req(req),
  .data_pointer(data_pointer), .req_ready(req_ready), .rsp(rsp)
);

// file: core_memory_space_addressing_bench.sv
`timescale 1ns/1ps
module core_memory_space_addressing_bench;
  logic                clk, rst, req_valid, fl_v;
  core_addr_pkg::req_t req;
  core_addr_pkg::rsp_t rsp;
  logic [15:0]         dp, pc, fl_a;
  logic [7:0]          acc, fl_d, a, y;
  logic                req_ready;
  logic [7:0]          im [256];
  logic [7:0]          sf [128];
  logic [7:0]          xr [2048];
  logic [7:0]          fl [int];
  int                  error_cnt, check_count, tot;

  core_memory_space_addressing dut_u (.clk(clk), .rst(rst), .req_valid(req_valid), .req(req),
    .data_pointer(dp), .accumulator(acc), .program_counter(pc), .flash_load_valid(fl_v),
    .flash_load_addr(fl_a), .flash_load_data(fl_d), .req_ready(req_ready), .rsp(rsp));

  // 100 MHz core clock
  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end

  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    check_count++;
    if (g !== e || $isunknown(g)) begin
      error_cnt++;
      $display("[ERR] %0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic print_verdict();
    $display("checks=%0d errors=%0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // flash is not reset, so only loaded bytes are ever read back
  task automatic load(input logic [15:0] ad);
    logic [7:0] d;
    d = 8'($urandom);
    fl[ad] = d;
    @(posedge clk);
    fl_v <= 1'h1;
    fl_a <= ad;
    fl_d <= d;
    @(posedge clk);
    fl_v <= 1'h0;
  endtask

  // model the access, issue it, then compare cost, routing and data
  task automatic op(input core_addr_pkg::mode_t m, input logic w,
                    input core_addr_pkg::bit_op_t b, input logic [7:0] ad, input logic [7:0] d);
    int n, lat, by;
    logic [15:0] ex, mk, ea;
    logic ee, ck;
    logic [7:0] ob;
    core_addr_pkg::space_t sp;
    ee = 1'h0; ck = !w; mk = 16'h00FF; ex = 16'h0000; sp = core_addr_pkg::space_none;
    lat = 4; by = 1;
    case (m)
      core_addr_pkg::mode_imm_byte: begin lat = 2; by = 2; ex = {8'h00, fl[pc + 1]}; end
      core_addr_pkg::mode_imm_data_pointer: begin
        lat = 3; by = 3; mk = 16'hFFFF; ex = {fl[pc + 1], fl[pc + 2]};
      end
      core_addr_pkg::mode_direct: begin
        lat = 2; by = 2;
        if (ad[7]) begin sp = core_addr_pkg::space_sfr; ex = sf[ad[6:0]]; if (w) sf[ad[6:0]] = d; end
        else begin sp = core_addr_pkg::space_iram; ex = im[ad]; if (w) im[ad] = d; end
      end
      core_addr_pkg::mode_register: begin
        lat = 1; sp = core_addr_pkg::space_iram; ex = im[ad[2:0]]; if (w) im[ad[2:0]] = d;
      end
      core_addr_pkg::mode_indirect: begin
        lat = 2; sp = core_addr_pkg::space_iram; ex = im[ad]; if (w) im[ad] = d;
      end
      core_addr_pkg::mode_ext_data_pointer: begin
        if (dp > 16'h07FF) begin ee = 1'h1; ck = 1'h1; mk = 16'hFFFF; ex = 16'h00FF; end
        else begin sp = core_addr_pkg::space_extended_internal_ram; ex = xr[dp[10:0]]; if (w) xr[dp[10:0]] = d; end
      end
      core_addr_pkg::mode_ext_ptr: begin
        sp = core_addr_pkg::space_extended_internal_ram; ex = xr[{3'h0, ad}]; if (w) xr[{3'h0, ad}] = d;
      end
      core_addr_pkg::mode_code_data_pointer: begin
        ea = dp + acc;
        if (ea > 16'hF7FF) begin ee = 1'h1; mk = 16'hFFFF; ex = 16'h00FF; end
        else begin sp = core_addr_pkg::space_flash; ex = fl[ea]; end
      end
      core_addr_pkg::mode_code_pc: begin
        sp = core_addr_pkg::space_flash;
        ea = pc + acc;
        ex = fl[ea];
      end
      core_addr_pkg::mode_jump_data_pointer: begin lat = 3; mk = 16'hFFFF; ex = dp + acc; end
      default: begin
        lat = 2; by = 2; ea = ad[7] ? {8'h00, ad[6:3], 3'h0} : {8'h00, 4'h2, ad[6:3]};
        ob = ad[7] ? sf[ea[6:0]] : im[ea];
        ex = 16'(ob[ad[2:0]]);
        sp = ad[7] ? core_addr_pkg::space_sfr : core_addr_pkg::space_iram;
        if (b == core_addr_pkg::bit_set) ob[ad[2:0]] = 1'h1;
        if (b == core_addr_pkg::bit_clear) ob[ad[2:0]] = 1'h0;
        if (b == core_addr_pkg::bit_invert) ob[ad[2:0]] = ~ob[ad[2:0]];
        if (ad[7]) sf[ea[6:0]] = ob; else im[ea] = ob;
      end
    endcase
    @(posedge clk);
    req_valid <= 1'h1;
    req <= '{m, w, b, ad, d};
    // hold the request until ready is sampled high at an edge
    do begin
      @(posedge clk);
    end while (req_ready !== 1'h1);
    req_valid <= 1'h0;
    n = 0;
    @(negedge clk);
    chk(16'(req_ready), 16'h0000);
    while (rsp.valid !== 1'h1 && n < 12) begin
      n++;
      @(negedge clk);
    end
    tot += n;
    chk(16'(req_ready), 16'h0001);
    chk(16'(n), 16'(lat));
    chk(16'(rsp.bytes), 16'(by));
    chk(16'(rsp.err), 16'(ee));
    if (sp != core_addr_pkg::space_none) chk(16'(rsp.space), 16'(sp));
    if (m == core_addr_pkg::mode_bit) chk(16'(rsp.bit_value), ex);
    else if (ck) chk(rsp.rdata & mk, ex);
  endtask

  // the whole run is under 500 cycles, so 200 us only trips on a hang
  initial begin
    #200000;
    error_cnt++;
    print_verdict();
  end

  initial begin
    void'($urandom(32'h5A66));
    rst = 1'h1; req_valid = 1'h0; req = '0; dp = 16'h0000; acc = 8'h00; pc = 16'h0000;
    fl_v = 1'h0; fl_a = 16'h0000; fl_d = 8'h00; error_cnt = 0; check_count = 0; tot = 0;
    repeat (3) @(posedge clk);
    rst <= 1'h0;
    repeat (2) @(posedge clk);
    // low ram through direct, register and indirect paths
    for (int i = 0; i < 8; i++) begin
      op(core_addr_pkg::mode_direct, 1'h1, core_addr_pkg::bit_read, 8'(i), 8'($urandom));
      op(core_addr_pkg::mode_register, 1'h0, core_addr_pkg::bit_read, 8'(i), 8'h00);
      op(core_addr_pkg::mode_indirect, 1'h0, core_addr_pkg::bit_read, 8'(i), 8'h00);
    end
    // upper half: same address, two distinct stores selected by mode
    for (int i = 0; i < 4; i++) begin
      a = (i == 0) ? 8'h80 : (i == 1) ? 8'hFF : 8'h80 | 8'($urandom);
      op(core_addr_pkg::mode_direct, 1'h1, core_addr_pkg::bit_read, a, 8'($urandom));
      op(core_addr_pkg::mode_indirect, 1'h1, core_addr_pkg::bit_read, a, 8'($urandom));
      op(core_addr_pkg::mode_direct, 0, core_addr_pkg::bit_read, a, 8'h00);
      op(core_addr_pkg::mode_indirect, 0, core_addr_pkg::bit_read, a, 8'h00);
    end
    // every bit operation in both halves, byte read back afterwards
    for (int i = 0; i < 8; i++) begin
      a = 8'($urandom);
      a[7] = i[0];
      y = a[7] ? {a[7:3], 3'h0} : {4'h2, a[6:3]};
      op(core_addr_pkg::mode_direct, 1'h1, core_addr_pkg::bit_read, y, 8'($urandom));
      op(core_addr_pkg::mode_bit, 0, core_addr_pkg::bit_op_t'(i[2:1]), a, 8'h00);
      op(core_addr_pkg::mode_direct, 0, core_addr_pkg::bit_read, y, 8'h00);
    end
    // extended ram through both pointers, top byte and beyond
    for (int i = 0; i < 4; i++) begin
      a = 8'($urandom);
      op(core_addr_pkg::mode_ext_ptr, 1'h1, core_addr_pkg::bit_read, a, 8'($urandom));
      dp = {8'h00, a};
      op(core_addr_pkg::mode_ext_data_pointer, 0, core_addr_pkg::bit_read, 8'h00, 8'h00);
      dp = (i == 0) ? 16'h07FF : {5'h00, 11'($urandom)};
      op(core_addr_pkg::mode_ext_data_pointer, 1'h1, core_addr_pkg::bit_read, 8'h00, 8'($urandom));
      op(core_addr_pkg::mode_ext_data_pointer, 0, core_addr_pkg::bit_read, 8'h00, 8'h00);
    end
    dp = 16'h0800;
    op(core_addr_pkg::mode_ext_data_pointer, 1'h1, core_addr_pkg::bit_read, 8'h00, 8'h5A);
    // immediates, code reads and indirect jump
    for (int i = 0; i < 3; i++) begin
      pc = 16'($urandom) & 16'h7FFF;
      acc = 8'($urandom);
      dp = 16'h8000 + 16'($urandom & 32'h3FFF);
      load(pc + 16'h0001);
      load(pc + 16'h0002);
      load(dp + acc);
      load(pc + acc);
      op(core_addr_pkg::mode_imm_byte, 0, core_addr_pkg::bit_read, 8'h00, 8'h00);
      op(core_addr_pkg::mode_imm_data_pointer, 0, core_addr_pkg::bit_read, 8'h00, 8'h00);
      op(core_addr_pkg::mode_code_data_pointer, 0, core_addr_pkg::bit_read, 8'h00, 8'h00);
      op(core_addr_pkg::mode_code_pc, 0, core_addr_pkg::bit_read, 8'h00, 8'h00);
      op(core_addr_pkg::mode_jump_data_pointer, 0, core_addr_pkg::bit_read, 8'h00, 8'h00);
    end
    dp = 16'hF7FF;
    acc = 8'h01;
    op(core_addr_pkg::mode_code_data_pointer, 0, core_addr_pkg::bit_read, 8'h00, 8'h00);
    // pointer load then pointer-based extended access
    tot = 0;
    op(core_addr_pkg::mode_imm_data_pointer, 0, core_addr_pkg::bit_read, 8'h00, 8'h00);
    dp = 16'h0100;
    op(core_addr_pkg::mode_ext_data_pointer, 1'h1, core_addr_pkg::bit_read, 8'h00, 8'h3C);
    chk(16'(tot), 16'h0007);
    print_verdict();
  end
endmodule
